// [rtl/ccs_pkg.sv]
// Shared constants and types for the CPU clock select block
package ccs_pkg;

  localparam int unsigned      REF_CLK_HZ     = 50_000_000;
  localparam int unsigned      ADDR_W         = 4;
  localparam logic [3:0]       SYSCFG_OFS     = 4'h0;
  localparam logic [3:0]       STATUS_OFS     = 4'h4;
  localparam logic [3:0]       CTRL_OFS       = 4'h8;
  localparam int unsigned      WD_DIS_BIT     = 4;
  localparam logic             WD_DIS_RST     = 1'b0;
  localparam int unsigned      ST_WDOG_BIT    = 0;
  localparam int unsigned      ST_UNLOCK_BIT  = 1;
  localparam int unsigned      ST_BACKUP_BIT  = 2;
  localparam int unsigned      ST_RSTBSY_BIT  = 3;
  localparam int unsigned      ST_MODE_LSB    = 4;
  localparam int unsigned      CTRL_BIRST_BIT = 0;
  localparam int unsigned      WDOG_OVF_CYCLES  = 16;
  localparam logic [10:0]      BIDIR_RST_HALVES = 11'h400;

  typedef enum logic [2:0] {
    CFG_MUL4   = 3'h7,
    CFG_MUL3   = 3'h6,
    CFG_MUL8   = 3'h5,
    CFG_MUL5   = 3'h4,
    CFG_DIRECT = 3'h3,
    CFG_MUL10  = 3'h2,
    CFG_PRESC  = 3'h1,
    CFG_MUL16  = 3'h0
  } ccs_cfg_t;

  typedef enum logic [3:0] {
    SRC_PLL    = 4'h1,
    SRC_PRESC  = 4'h2,
    SRC_DIRECT = 4'h4,
    SRC_BACKUP = 4'h8
  } ccs_src_t;

  function automatic logic [4:0] ccs_factor(input ccs_cfg_t m);
    logic [4:0] f;
    f = 5'h01;
    unique case (m)
      CFG_MUL4:   f = 5'h04;
      CFG_MUL3:   f = 5'h03;
      CFG_MUL8:   f = 5'h08;
      CFG_MUL5:   f = 5'h05;
      CFG_DIRECT: f = 5'h01;
      CFG_MUL10:  f = 5'h0a;
      CFG_PRESC:  f = 5'h01;
      CFG_MUL16:  f = 5'h10;
    endcase
    return f;
  endfunction

  function automatic ccs_src_t ccs_src_of(input ccs_cfg_t m);
    ccs_src_t s;
    s = SRC_PLL;
    if (m == CFG_DIRECT) begin
      s = SRC_DIRECT;
    end else if (m == CFG_PRESC) begin
      s = SRC_PRESC;
    end
    return s;
  endfunction

endpackage

// [rtl/ccs_owd_if.sv]
// Link between clock select and oscillator watchdog counter
interface ccs_wdog_if;
  logic enable;
  logic pll_tick;
  logic ext_edge;
  logic overflow;

  modport mon (input enable, input pll_tick, input ext_edge, output overflow);
  modport ctl (output enable, output pll_tick, output ext_edge, input overflow);
endinterface

// [rtl/ccs_osc_wd.sv]
// Oscillator watchdog counter on the reference clock, counting free-running PLL ticks
module ccs_osc_wd
  import ccs_pkg::*;
#(
  parameter int unsigned OVF_CYCLES = WDOG_OVF_CYCLES
) (
  input  wire logic  i_ref_clk,
  input  wire logic  i_reset_n,
  ccs_wdog_if.mon    bus
);

  localparam int unsigned CW = $clog2(OVF_CYCLES + 1);

  generate
    if (OVF_CYCLES < 2) begin : g_chk
      $error("OVF_CYCLES too small");
    end
  endgenerate

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          ovf;
  } ccs_wd_state_t;

  ccs_wd_state_t s_q;
  ccs_wd_state_t s_d;

  always_comb begin
    s_d     = s_q;
    s_d.ovf = 1'b0;
    if (!bus.enable || bus.ext_edge) begin
      s_d.cnt = '0;
    end else if (bus.pll_tick) begin
      if (s_q.cnt == CW'(OVF_CYCLES - 1)) begin
        s_d.cnt = '0;
        s_d.ovf = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + CW'(1);
      end
    end
    if (!i_reset_n) begin
      s_d = '0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    s_q <= s_d;
  end

  assign bus.overflow = s_q.ovf;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  wd_edge_clear_a: assert property (bus.ext_edge |=> s_q.cnt == '0 && !bus.overflow)
    else $error("Watchdog counter not cleared by clock edge");
  wd_ovf_count_a: assert property (bus.overflow |-> $past(s_q.cnt) == CW'(OVF_CYCLES - 1) && $past(bus.pll_tick))
    else $error("Watchdog overflow at wrong count");

endmodule

// [rtl/ccs_clock_select.sv]
// CPU clock source selection, prescaler, direct drive and backup switch
// What this block does
// - Mode chosen from config pins during reset.
// - Pin patterns map to the eight clock modes.
// - Pattern 001 halves input; half period one input period.
// - Pattern 011 bypasses PLL; CPU follows input pin.
// - Two direct-drive half periods equal one input period.
// - Other patterns enable PLL multiplying by factor.
// - PLL resynchronises every Fth input transition.
// - Both CPU clock edges mark timing events.
// - Disable bit chooses PLL free-running or off.
// - Watchdog only in direct or prescaler modes.
// - Watchdog enabled at reset; bit 4 disables.
// - PLL ticks count; input transitions clear counter.
// - Counter overflows after 16 quiet PLL cycles.
// - Overflow switches to backup clock, flags request.
// - Backup clock held until next reset.
// - Watchdog disabled: external clock, PLL off.
// - PLL unlock raises request, disconnects reference.
// - Bidirectional reset drives pin low 1024 half periods.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
module ccs_clock_select
  import ccs_pkg::*;
#(
  parameter int unsigned DATA_W = 16
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset_n,
  input  wire logic [2:0]        i_clock_config_pins,
  input  wire logic              i_clock_input_pin,
  input  wire logic              i_pll_tick,
  input  wire logic              i_pll_locked,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  output logic                   o_cpu_clk,
  output logic                   o_cpu_edge,
  output logic                   o_pll_enable,
  output logic                   o_pll_ref_connect,
  output logic                   o_osc_bypass,
  output logic                   o_pll_resync,
  output logic                   o_wdog_req,
  output logic                   o_unlock_req,
  output logic                   o_reset_pin_o,
  output logic                   o_reset_pin_oe_n
);

  generate
    if (DATA_W < 8) begin : g_chk
      $error("DATA_W must be at least 8");
    end
  endgenerate

  typedef struct packed {
    ccs_cfg_t          mode;
    ccs_src_t          src;
    logic              cpu_clk;
    logic              cpu_edge;
    logic              ext;
    logic              wd_dis;
    logic              wdog_flag;
    logic              unlock_flag;
    logic              lock_seen;
    logic              ref_disc;
    logic              rst_busy;
    logic [10:0]       rst_cnt;
    logic [4:0]        sync_cnt;
    logic              resync;
    logic [DATA_W-1:0] rdata;
  } ccs_state_t;

  ccs_state_t s_q;
  ccs_state_t s_d;
  logic       ext_edge;
  logic       ext_rise;
  logic       wd_ovf;
  logic       lock_lost;
  logic       birst_start;

  ccs_wdog_if u_wdog_bus ();

  ccs_osc_wd #(
    .OVF_CYCLES (WDOG_OVF_CYCLES)
  ) u_osc_wd (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .bus       (u_wdog_bus.mon)
  );

  assign ext_edge            = i_clock_input_pin ^ s_q.ext;
  assign ext_rise            = i_clock_input_pin & ~s_q.ext;
  assign u_wdog_bus.enable   = (s_q.src == SRC_PRESC || s_q.src == SRC_DIRECT) && !s_q.wd_dis;
  assign u_wdog_bus.pll_tick = i_pll_tick;
  assign u_wdog_bus.ext_edge = ext_edge;
  assign wd_ovf              = u_wdog_bus.overflow;
  assign lock_lost          = (s_q.src == SRC_PLL) && s_q.lock_seen && !i_pll_locked;
  assign birst_start        = i_wr && i_addr == CTRL_OFS && i_wdata[CTRL_BIRST_BIT] && !s_q.rst_busy;

  always_comb begin
    logic tog;
    tog       = 1'b0;
    s_d       = s_q;
    s_d.ext   = i_clock_input_pin;
    s_d.rdata = '0;
    s_d.resync = 1'b0;

    unique case (s_q.src)
      SRC_PLL:    tog = i_pll_tick;
      SRC_BACKUP: tog = i_pll_tick;
      SRC_PRESC:  tog = ext_rise;
      SRC_DIRECT: tog = ext_edge;
    endcase
    s_d.cpu_clk = s_q.cpu_clk ^ tog;
    s_d.cpu_edge = tog;

    if (s_q.src == SRC_PLL && ext_edge) begin
      if (s_q.sync_cnt + 5'h01 >= ccs_factor(s_q.mode)) begin
        s_d.sync_cnt = 5'h00;
        s_d.resync   = 1'b1;
      end else begin
        s_d.sync_cnt = s_q.sync_cnt + 5'h01;
      end
    end

    if (i_wr) begin
      unique case (i_addr)
        SYSCFG_OFS: s_d.wd_dis = i_wdata[WD_DIS_BIT];
        STATUS_OFS: begin
          if (i_wdata[ST_WDOG_BIT]) begin
            s_d.wdog_flag = 1'b0;
          end
          if (i_wdata[ST_UNLOCK_BIT]) begin
            s_d.unlock_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    if (birst_start) begin
      s_d.rst_busy = 1'b1;
      s_d.rst_cnt  = 11'h000;
    end else if (s_q.rst_busy && tog) begin
      if (s_q.rst_cnt == BIDIR_RST_HALVES - 11'h001) begin
        s_d.rst_busy = 1'b0;
      end else begin
        s_d.rst_cnt = s_q.rst_cnt + 11'h001;
      end
    end

    if (i_rd) begin
      unique case (i_addr)
        SYSCFG_OFS: s_d.rdata[WD_DIS_BIT] = s_q.wd_dis;
        STATUS_OFS: begin
          s_d.rdata[ST_WDOG_BIT]                 = s_q.wdog_flag;
          s_d.rdata[ST_UNLOCK_BIT]               = s_q.unlock_flag;
          s_d.rdata[ST_BACKUP_BIT]               = s_q.src == SRC_BACKUP;
          s_d.rdata[ST_RSTBSY_BIT]               = s_q.rst_busy;
          s_d.rdata[ST_MODE_LSB+2:ST_MODE_LSB]   = s_q.mode;
        end
        default: ;
      endcase
    end

    if (s_q.src == SRC_PLL && i_pll_locked) begin
      s_d.lock_seen = 1'b1;
    end
    if (lock_lost) begin
      s_d.ref_disc    = 1'b1;
      s_d.unlock_flag = 1'b1;
    end
    if (wd_ovf && u_wdog_bus.enable) begin
      s_d.src       = SRC_BACKUP;
      s_d.wdog_flag = 1'b1;
    end

    if (!i_reset_n) begin
      s_d        = '0;
      s_d.ext    = i_clock_input_pin;
      s_d.wd_dis = WD_DIS_RST;
      s_d.mode   = ccs_cfg_t'(i_clock_config_pins);
      s_d.src    = ccs_src_of(ccs_cfg_t'(i_clock_config_pins));
    end
  end

  always_ff @(posedge i_ref_clk) begin
    s_q <= s_d;
  end

  always_comb begin
    o_pll_enable = 1'b1;
    unique case (s_q.src)
      SRC_PLL:    o_pll_enable = 1'b1;
      SRC_BACKUP: o_pll_enable = 1'b1;
      SRC_PRESC:  o_pll_enable = !s_q.wd_dis;
      SRC_DIRECT: o_pll_enable = !s_q.wd_dis;
    endcase
  end

  assign o_rdata           = s_q.rdata;
  assign o_cpu_clk         = s_q.cpu_clk;
  assign o_cpu_edge        = s_q.cpu_edge;
  assign o_pll_ref_connect = (s_q.src == SRC_PLL) && !s_q.ref_disc;
  assign o_osc_bypass      = s_q.mode == CFG_DIRECT;
  assign o_pll_resync      = s_q.resync;
  assign o_wdog_req        = s_q.wdog_flag;
  assign o_unlock_req      = s_q.unlock_flag;
  assign o_reset_pin_o     = 1'b0;
  assign o_reset_pin_oe_n  = !s_q.rst_busy;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  mode_hold_a: assert property ($past(i_reset_n) |-> $stable(s_q.mode))
    else $error("Clock mode changed outside reset");
  mode_map_a: assert property ($rose(i_reset_n) |-> s_q.src == ccs_src_of(s_q.mode))
    else $error("Clock source does not match pin pattern");
  pll_mode_a: assert property (s_q.src == SRC_PLL |-> o_pll_enable && !u_wdog_bus.enable
                               && s_q.mode != CFG_DIRECT && s_q.mode != CFG_PRESC)
    else $error("PLL mode settings wrong");
  presc_half_a: assert property (s_q.src == SRC_PRESC && ext_rise && !wd_ovf
                                 |=> o_cpu_edge && $changed(o_cpu_clk))
    else $error("Prescaler did not toggle on input rise");
  presc_fall_a: assert property (s_q.src == SRC_PRESC && !ext_rise |=> !o_cpu_edge)
    else $error("Prescaler toggled without input rise");
  direct_follow_a: assert property (s_q.src == SRC_DIRECT && !wd_ovf
                                    |=> o_cpu_clk == ($past(i_clock_input_pin) ^ $past(s_q.ext) ^ $past(s_q.cpu_clk)))
    else $error("Direct drive not following input");
  wd_dis_off_a: assert property ((s_q.src == SRC_PRESC || s_q.src == SRC_DIRECT)
                                 |-> o_pll_enable == !s_q.wd_dis)
    else $error("PLL enable wrong for disable bit");
  wdog_reset_a: assert property ($rose(i_reset_n) |-> !s_q.wd_dis && u_wdog_bus.enable == (s_q.src != SRC_PLL))
    else $error("Watchdog not enabled after reset");
  wdog_switch_a: assert property (wd_ovf && u_wdog_bus.enable |=> s_q.src == SRC_BACKUP && o_wdog_req)
    else $error("Overflow did not switch to backup");
  backup_hold_a: assert property (s_q.src == SRC_BACKUP |=> s_q.src == SRC_BACKUP && o_pll_enable)
    else $error("Backup clock released without reset");
  unlock_disc_a: assert property (lock_lost |=> !o_pll_ref_connect && o_unlock_req ##1 !o_pll_ref_connect)
    else $error("Unlock did not disconnect reference");
  resync_mode_a: assert property (o_pll_resync |-> s_q.src == SRC_PLL)
    else $error("Resync outside PLL mode");
  edge_clk_a: assert property (o_cpu_edge |-> $changed(o_cpu_clk))
    else $error("CPU edge without clock change");
  birst_len_a: assert property ($fell(s_q.rst_busy) |-> $past(s_q.rst_cnt) == BIDIR_RST_HALVES - 11'h001)
    else $error("Reset pulse length wrong");
  birst_drive_a: assert property (birst_start |=> !o_reset_pin_oe_n [*8])
    else $error("Reset pin not driven");

  cfg_sample_a: assert property (disable iff (1'b0) !i_reset_n |=> s_q.mode == ccs_cfg_t'($past(i_clock_config_pins)))
    else $error("Mode not taken from pins in reset");

  reset_state_a: assert property (disable iff (1'b0) !i_reset_n
                                  |=> !s_q.wd_dis && !o_wdog_req && !o_unlock_req && o_reset_pin_oe_n)
    else $error("Reset state wrong");

  presc_src_a: assert property ($rose(i_reset_n) && s_q.mode == CFG_PRESC |-> s_q.src == SRC_PRESC)
    else $error("Prescaler pattern not prescaler source");

  direct_src_a: assert property ($rose(i_reset_n) && s_q.mode == CFG_DIRECT |-> s_q.src == SRC_DIRECT)
    else $error("Direct pattern not direct source");

  pll_src_a: assert property ($rose(i_reset_n) && s_q.mode != CFG_PRESC && s_q.mode != CFG_DIRECT
                              |-> s_q.src == SRC_PLL)
    else $error("Multiplier pattern not PLL source");

  pll_tick_a: assert property (s_q.src == SRC_PLL && i_pll_tick |=> o_cpu_edge)
    else $error("PLL tick did not toggle clock");

  pll_quiet_a: assert property (s_q.src == SRC_PLL && !i_pll_tick |=> !o_cpu_edge)
    else $error("PLL clock toggled without tick");

  backup_tick_a: assert property (s_q.src == SRC_BACKUP && i_pll_tick |=> o_cpu_edge)
    else $error("Backup tick did not toggle clock");

  direct_edge_a: assert property (s_q.src == SRC_DIRECT && ext_edge |=> o_cpu_edge)
    else $error("Direct drive missed input transition");

  direct_quiet_a: assert property (s_q.src == SRC_DIRECT && !ext_edge |=> !o_cpu_edge)
    else $error("Direct drive toggled without transition");

  resync_edge_a: assert property (o_pll_resync |-> $past(ext_edge))
    else $error("Resync without input transition");

  sync_bound_a: assert property (s_q.src == SRC_PLL |-> s_q.sync_cnt < ccs_factor(s_q.mode))
    else $error("Resync counter beyond factor");

  clk_edge_a: assert property ($changed(o_cpu_clk) |-> o_cpu_edge)
    else $error("Clock change without edge pulse");

  wd_pll_on_a: assert property (u_wdog_bus.enable |-> o_pll_enable)
    else $error("Watchdog running with PLL off");

  wd_dis_quiet_a: assert property (s_q.wd_dis |-> !u_wdog_bus.enable)
    else $error("Watchdog enabled while disabled");

  wd_dis_stay_a: assert property (s_q.wd_dis && s_q.src != SRC_BACKUP |=> s_q.src != SRC_BACKUP)
    else $error("Backup switch while watchdog disabled");

  wdog_src_a: assert property ($rose(o_wdog_req) |-> s_q.src == SRC_BACKUP)
    else $error("Watchdog request without backup");

  wdog_hold_a: assert property (o_wdog_req && !(i_wr && i_addr == STATUS_OFS && i_wdata[ST_WDOG_BIT])
                                |=> o_wdog_req)
    else $error("Watchdog request lost");

  wdog_clear_a: assert property (i_wr && i_addr == STATUS_OFS && i_wdata[ST_WDOG_BIT]
                                 && !(wd_ovf && u_wdog_bus.enable) |=> !o_wdog_req)
    else $error("Watchdog request not cleared");

  unlock_hold_a: assert property (o_unlock_req && !(i_wr && i_addr == STATUS_OFS && i_wdata[ST_UNLOCK_BIT])
                                  |=> o_unlock_req)
    else $error("Unlock request lost");

  unlock_clear_a: assert property (i_wr && i_addr == STATUS_OFS && i_wdata[ST_UNLOCK_BIT] && !lock_lost
                                   |=> !o_unlock_req)
    else $error("Unlock request not cleared");

  bypass_ref_a: assert property (o_osc_bypass |-> !o_pll_ref_connect)
    else $error("Reference connected in direct drive");

  ref_hold_a: assert property (!o_pll_ref_connect |=> !o_pll_ref_connect)
    else $error("Reference restored without reset");

  rst_start_a: assert property (birst_start |=> s_q.rst_busy && s_q.rst_cnt == 11'h000)
    else $error("Reset pulse did not start");

  rst_early_a: assert property (s_q.rst_busy && s_q.rst_cnt != BIDIR_RST_HALVES - 11'h001
                                |=> s_q.rst_busy)
    else $error("Reset pulse ended early");

  rst_idle_a: assert property (!s_q.rst_busy && !birst_start |=> !s_q.rst_busy)
    else $error("Reset pulse without start");

  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("Read data outside read cycle");

  rdata_unmapped_a: assert property ($past(i_rd) && $past(i_addr) != SYSCFG_OFS && $past(i_addr) != STATUS_OFS
                                     |-> o_rdata == '0)
    else $error("Unmapped read not zero");

  mode_read_a: assert property ($past(i_rd) && $past(i_addr) == STATUS_OFS
                                |-> o_rdata[ST_MODE_LSB+2:ST_MODE_LSB] == s_q.mode)
    else $error("Mode field read wrong");

  backup_c: cover property (wd_ovf && u_wdog_bus.enable);
  direct_c: cover property (s_q.src == SRC_DIRECT && o_cpu_edge);
  unlock_c: cover property (lock_lost);
  birst_c:  cover property ($fell(s_q.rst_busy));
  resync_c: cover property (o_pll_resync);

endmodule

// [testbench/ccs_osc_model.sv]
// Behavioural external clock source driving the clock input pin
module ccs_osc_model #(
  parameter int HALF = 3
) (
  input  wire logic i_ref_clk,
  input  wire logic i_run,
  output logic      o_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial o_clk = 1'b0;
  // Square wave while running; a failed source freezes its level
  always @(posedge i_ref_clk) begin
    if (i_run) begin
      cnt = (cnt + 1) % HALF;
      if (cnt == 0) begin
        o_clk <= ~o_clk;
      end
    end
  end
endmodule

// [testbench/ccs_clock_select_test.sv]
// Self-checking bench for the CPU clock select block
module ccs_clock_select_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ccs_pkg::*;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, tick_en = 0, tick = 0, locked = 1, run = 0, xin_q = 0;
  logic [2:0]  pins = 3'h7;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdat;
  wire  [15:0] rdata;
  wire         cpu_clk, edge_p, pll_en, ref_con, byp, resync, wdog, unl, rst_o, oe_n, xin;
  int          bad_count = 0, n_checks = 0, cyc = 0, n_tr = 0, n_ed = 0, n_rs = 0, k;
  int          ft[8] = '{16, 1, 10, 1, 5, 8, 3, 4};

  always #10 clk = ~clk;
  always @(posedge clk) tick <= tick_en & ~tick;

  ccs_osc_model i_osc (.i_ref_clk(clk), .i_run(run), .o_clk(xin));

  ccs_clock_select i_dut (
    .i_ref_clk(clk), .i_reset_n(rst_n), .i_clock_config_pins(pins), .i_clock_input_pin(xin),
    .i_pll_tick(tick), .i_pll_locked(locked), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_cpu_clk(cpu_clk), .o_cpu_edge(edge_p), .o_pll_enable(pll_en),
    .o_pll_ref_connect(ref_con), .o_osc_bypass(byp), .o_pll_resync(resync), .o_wdog_req(wdog),
    .o_unlock_req(unl), .o_reset_pin_o(rst_o), .o_reset_pin_oe_n(oe_n)
  );

  // Transition, edge and resync counters
  always @(posedge clk) begin
    xin_q <= xin;
    if (!rst_n) begin
      n_tr <= 0;
      n_ed <= 0;
      n_rs <= 0;
    end else begin
      n_tr <= n_tr + int'(xin != xin_q);
      n_ed <= n_ed + int'(edge_p);
      n_rs <= n_rs + int'(resync);
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      results();
    end
  end

  task automatic chkw(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic [2:0] p);
    rst_n <= 1'b0;
    pins  <= p;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    pins <= ~p;
    @(posedge clk);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask

  task automatic run_clk(input int n);
    int tgt;
    tgt = n_tr + n;
    run <= 1'b1;
    for (int i = 0; i < 5000 && n_tr < tgt; i++) @(posedge clk);
    run <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  initial begin
    // Every pattern: mode field, source outputs, resync counts; edge counts for patterns 001 and 011
    for (int p = 0; p < 8; p++) begin
      do_reset(3'(p));
      rd_reg(STATUS_OFS, rdat);
      chkw(rdat & 16'h0070, {9'h000, 3'(p), 4'h0});
      chkb(byp, p == 3);
      chkb(pll_en, 1'b1);
      chkb(ref_con, p != 1 && p != 3);
      run_clk(48);
      chkw(16'(n_rs), (p == 1 || p == 3) ? 16'h0000 : 16'(48 / ft[p]));
      if (p == 3) chkw(16'(n_ed), 16'd48);
      if (p == 1) chkw(16'(n_ed), 16'd24);
      chkb(cpu_clk, 1'b0);
    end
    $display("test modes done");
    // Watchdog fires after quiet PLL ticks and holds backup
    do_reset(3'h3);
    tick_en <= 1'b1;
    run_clk(20);
    chkb(wdog, 1'b0);
    repeat (20) @(posedge clk);
    chkb(wdog, 1'b0);
    repeat (20) @(posedge clk);
    chkb(wdog, 1'b1);
    run_clk(10);
    rd_reg(STATUS_OFS, rdat);
    chkw(rdat & 16'h0005, 16'h0005);
    wr_reg(STATUS_OFS, 16'h0001);
    rd_reg(STATUS_OFS, rdat);
    chkw(rdat & 16'h0005, 16'h0004);
    tick_en <= 1'b0;
    $display("test watchdog done");
    // Disable bit switches PLL off and watchdog stays quiet
    do_reset(3'h1);
    rd_reg(SYSCFG_OFS, rdat);
    chkw(rdat, 16'h0000);
    wr_reg(SYSCFG_OFS, 16'h0010);
    rd_reg(SYSCFG_OFS, rdat);
    chkw(rdat, 16'h0010);
    chkb(pll_en, 1'b0);
    tick_en <= 1'b1;
    repeat (50) @(posedge clk);
    chkb(wdog, 1'b0);
    run_clk(8);
    chkw(16'(n_ed), 16'd4);
    tick_en <= 1'b0;
    rd_reg(4'hc, rdat);
    chkw(rdat, 16'h0000);
    $display("test disable done");
    // Lock loss disconnects the reference until reset
    do_reset(3'h7);
    locked <= 1'b0;
    repeat (3) @(posedge clk);
    chkb(unl, 1'b1);
    chkb(ref_con, 1'b0);
    locked <= 1'b1;
    repeat (4) @(posedge clk);
    chkb(ref_con, 1'b0);
    wr_reg(STATUS_OFS, 16'h0002);
    rd_reg(STATUS_OFS, rdat);
    chkw(rdat & 16'h0002, 16'h0000);
    chkb(ref_con, 1'b0);
    $display("test unlock done");
    // Bidirectional reset pulse length in half periods
    do_reset(3'h3);
    wr_reg(CTRL_OFS, 16'h0001);
    @(posedge clk);
    run <= 1'b1;
    #1;
    chkb(oe_n, 1'b0);
    chkb(rst_o, 1'b0);
    k = 0;
    for (int i = 0; i < 8000; i++) begin
      @(posedge clk);
      #1;
      if (edge_p) k++;
      if (oe_n === 1'b1) break;
    end
    @(posedge clk);
    run <= 1'b0;
    chkw(16'(k), 16'd1024);
    $display("test bidirectional reset done");
    results();
  end
endmodule
